// ===== css_pkg.sv
package css_pkg;
    // -----------------------------------------------------------------
    // Clock and time base
    // -----------------------------------------------------------------
    localparam int unsigned CLK_HZ   = 40_000_000;
    localparam int unsigned BASE_US  = 1000;
    localparam int unsigned BASE_CYC = (CLK_HZ / 1_000_000) * BASE_US;
    localparam int unsigned TMR_W    = 25;
    localparam int unsigned BLK_W    = 10;
    localparam logic [TMR_W-1:0] TMR_ONE = 25'd1;
    localparam logic [BLK_W-1:0] BLK_ONE = 10'd1;
    // Times in milliseconds (one time base step each)
    localparam logic [BLK_W-1:0] BLINK_LAST_MS = 10'd999;
    localparam logic [BLK_W-1:0] PQ_ON_MS      = 10'd50;
    localparam logic [BLK_W-1:0] TO_ON_MS      = 10'd500;
    localparam logic [TMR_W-1:0] T_DEGLITCH_MS = 25'd32;
    localparam logic [TMR_W-1:0] T_PQ_MS       = 25'd1800000;
    localparam logic [TMR_W-1:0] T_FC_MS       = 25'd18000000;
    localparam logic [TMR_W-1:0] T_TERM_MS     = 25'd30000;
    localparam logic [TMR_W-1:0] T_TO_MS       = 25'd1800000;
    localparam logic [TMR_W-1:0] T_WD_MS       = 25'd80000;
    // -----------------------------------------------------------------
    // Register map (byte addresses)
    // -----------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_WDOG = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ  = 8'h0c;
    localparam int unsigned CTRL_IND_EN_BIT = 0;
    localparam int unsigned CTRL_WD_EN_BIT  = 1;
    localparam int unsigned CTRL_MODE_BIT   = 2;
    localparam int unsigned CTRL_ILIM_LSB   = 8;
    localparam int unsigned ILIM_W          = 7;
    localparam logic [ILIM_W-1:0] ILIM_RESET = 7'h0f;
    localparam logic [1:0] WDCLR_KEY = 2'h1;
    localparam int unsigned STAT_CHARGER_OK_FLAG_BIT = 0;
    localparam int unsigned STAT_BYPASS_OK_FLAG_BIT = 1;
    localparam int unsigned STAT_CHG_DTL_LSB = 4;
    localparam int unsigned STAT_BYP_DTL_LSB = 8;
    localparam int unsigned STAT_STATE_LSB  = 16;
    localparam int unsigned IRQ_CHG_BIT = 0;
    localparam int unsigned IRQ_BYP_BIT = 1;
    // Detail codes
    localparam logic [3:0] DTL_DEAD   = 4'h0;
    localparam logic [3:0] DTL_CC     = 4'h1;
    localparam logic [3:0] DTL_TOPOFF = 4'h3;
    localparam logic [3:0] DTL_DONE   = 4'h4;
    localparam logic [3:0] DTL_TFAULT = 4'h6;
    localparam logic [3:0] DTL_WDOG   = 4'hb;
    localparam logic [3:0] DTL_RESET  = 4'hf;
    localparam logic [3:0] BYP_DTL_OK   = 4'h0;
    localparam logic [3:0] BYP_DTL_VREG = 4'h8;
    // -----------------------------------------------------------------
    // Charger states
    // -----------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_OFF    = 9'h001, ST_DEAD   = 9'h002, ST_LOWPQ  = 9'h004,
        ST_CC     = 9'h008, ST_CV     = 9'h010, ST_TOPOFF = 9'h020,
        ST_DONE   = 9'h040, ST_TFAULT = 9'h080, ST_WDSUS  = 9'h100
    } css_state_e;
endpackage : css_pkg

// ===== css_reg_if.sv
`timescale 1ns/1ps
interface css_reg_if;
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    modport bus  (output wr, rd, addr, wdata, be, input rdata);
    modport regs (input wr, rd, addr, wdata, be, output rdata);
endinterface : css_reg_if

// ===== css_tick_gen.sv
`timescale 1ns/1ps
module css_tick_gen #(
    parameter int unsigned CYCLES = 40000
) (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_arst_n,
    // Time base
    output logic      o_tick
);
    import css_pkg::*;
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } css_tick_s;
    css_tick_s q, d;
    always_comb begin
        d      = q;
        d.tick = (q.cnt == LAST);
        d.cnt  = d.tick ? '0 : q.cnt + CW'(1);
    end
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign o_tick = q.tick;
endmodule : css_tick_gen

// ===== css_avmm_slave.sv
`timescale 1ns/1ps
module css_avmm_slave (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_arst_n,
    // Avalon-MM slave
    input  wire logic [7:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    output logic [31:0]      o_readdata,
    output logic             o_waitrequest,
    // Register side
    css_reg_if.bus           reg_bus
);
    import css_pkg::*;
    typedef enum logic [2:0] {
        PH_IDLE = 3'h1, PH_ACC = 3'h2, PH_ANS = 3'h4
    } css_phase_e;
    typedef struct packed {
        css_phase_e  ph;
        logic        wait_r;
        logic [31:0] rdata;
    } css_slv_s;
    css_slv_s q, d;
    // The request is held by the master, so the strobe may look at it
    assign reg_bus.wr    = (q.ph == PH_ACC) && i_write;
    assign reg_bus.rd    = (q.ph == PH_ACC) && i_read;
    assign reg_bus.addr  = i_address;
    assign reg_bus.wdata = i_writedata;
    assign reg_bus.be    = i_byteenable;
    always_comb begin
        d = q;
        unique case (q.ph)
            PH_IDLE: begin
                if (i_read || i_write) d.ph = PH_ACC;
            end
            PH_ACC: begin
                d.ph     = PH_ANS;
                d.wait_r = 1'b0;
                d.rdata  = i_read ? reg_bus.rdata : 32'h0;
            end
            PH_ANS: begin
                d.ph     = PH_IDLE;
                d.wait_r = 1'b1;
            end
            default: begin
                d.ph     = PH_IDLE;
                d.wait_r = 1'b1;
            end
        endcase
    end
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= '{ph: PH_IDLE, wait_r: 1'b1, rdata: 32'h0};
        end else begin
            q <= d;
        end
    end
    assign o_readdata    = q.rdata;
    assign o_waitrequest = q.wait_r;
endmodule : css_avmm_slave

// ===== css_charger_seq.sv
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
module css_charger_seq #(
    parameter int unsigned TICK_CYCLES = css_pkg::BASE_CYC
) (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_arst_n,
    // Avalon-MM slave
    input  wire logic [7:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    output logic [31:0]      o_readdata,
    output logic             o_waitrequest,
    // Analog comparator levels
    input  wire logic        i_charger_supply_input,
    input  wire logic        i_battery_present_sense_n,
    input  wire logic        i_batt_above_dead,
    input  wire logic        i_batt_above_low,
    input  wire logic        i_batt_above_reg,
    input  wire logic        i_batt_below_restart,
    input  wire logic        i_chg_cur_below_topoff,
    input  wire logic        i_die_above_die_regulation_temperature,
    input  wire logic        i_in_current_limited,
    input  wire logic        i_input_below_reg,
    input  wire logic        i_ilim_at_floor,
    input  wire logic        i_vreg_loop_active,
    input  wire logic        i_otp_ovp_polarity,
    // Power stage controls
    output logic             o_prequal_indicator_output,
    output logic             o_charge_indicator_output,
    output logic             o_ovp_switch_drive,
    output logic             o_charger_input_on,
    output logic             o_buck_enable,
    output logic             o_charge_enable,
    output logic             o_charge_current_reduce,
    output logic [6:0]       o_input_current_limit_setting
);
    import css_pkg::*;

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        css_state_e        state;
        logic [TMR_W-1:0]  state_ms;
        logic [TMR_W-1:0]  term_ms;
        logic [TMR_W-1:0]  wd_ms;
        logic [BLK_W-1:0]  blink_ms;
        logic              reported;
        logic              ind_en;
        logic              wd_en;
        logic              mode_on;
        logic [ILIM_W-1:0] ilim;
        logic              charger_ok_flag;
        logic              bypass_ok_flag;
        logic [3:0]        chg_dtl;
        logic [3:0]        byp_dtl;
        logic              chg_irq;
        logic              byp_irq;
        logic              chg_pend;
        logic              byp_pend;
        logic              vreg_seen;
        logic              input_off;
        logic              pq_led;
        logic              chg_led;
        logic              ovp_drive;
        logic              input_on;
        logic              buck_en;
        logic              chg_en;
        logic              cur_reduce;
    } css_core_s;

    // Every control bit takes its default on global shutdown
    localparam css_core_s CORE_RST = '{
        state:   ST_OFF,
        ind_en:  1'b1,
        mode_on: 1'b1,
        ilim:    ILIM_RESET,
        chg_dtl: DTL_RESET,
        default: '0
    };

    css_core_s  q, d;
    css_reg_if  regs ();
    logic       tick;
    css_state_e nxt;
    logic       wd_kick;
    logic       irq_read;
    logic       wd_expired;
    logic       start_ok;
    logic       charging;
    logic       entering;
    logic       fast;

    // -----------------------------------------------------------------
    // Submodules
    // -----------------------------------------------------------------
    // One millisecond base shared by blink, deglitch and timeouts
    css_tick_gen #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .i_clock  (i_clock),
        .i_arst_n (i_arst_n),
        .o_tick   (tick)
    );

    css_avmm_slave u_slave (
        .i_clock       (i_clock),
        .i_arst_n      (i_arst_n),
        .i_address     (i_address),
        .i_read        (i_read),
        .i_write       (i_write),
        .i_writedata   (i_writedata),
        .i_byteenable  (i_byteenable),
        .o_readdata    (o_readdata),
        .o_waitrequest (o_waitrequest),
        .reg_bus       (regs.bus)
    );

    // -----------------------------------------------------------------
    // Register read
    // -----------------------------------------------------------------
    always_comb begin
        regs.rdata = 32'h0;
        unique case (regs.addr)
            REG_CTRL: begin
                regs.rdata[CTRL_IND_EN_BIT] = q.ind_en;
                regs.rdata[CTRL_WD_EN_BIT]  = q.wd_en;
                regs.rdata[CTRL_MODE_BIT]   = q.mode_on;
                regs.rdata[CTRL_ILIM_LSB +: ILIM_W] = q.ilim;
            end
            REG_STAT: begin
                regs.rdata[STAT_CHARGER_OK_FLAG_BIT]       = q.charger_ok_flag;
                regs.rdata[STAT_BYPASS_OK_FLAG_BIT]       = q.bypass_ok_flag;
                regs.rdata[STAT_CHG_DTL_LSB +: 4] = q.chg_dtl;
                regs.rdata[STAT_BYP_DTL_LSB +: 4] = q.byp_dtl;
                regs.rdata[STAT_STATE_LSB +: 9]   = q.state;
            end
            REG_IRQ: begin
                regs.rdata[IRQ_CHG_BIT] = q.chg_irq;
                regs.rdata[IRQ_BYP_BIT] = q.byp_irq;
            end
            default: regs.rdata = 32'h0;
        endcase
    end

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        d = q;
        // Host side register effects
        if (regs.wr && regs.addr == REG_CTRL) begin
            if (regs.be[0]) begin
                d.ind_en  = regs.wdata[CTRL_IND_EN_BIT];
                d.wd_en   = regs.wdata[CTRL_WD_EN_BIT];
                d.mode_on = regs.wdata[CTRL_MODE_BIT];
            end
            if (regs.be[1]) begin
                d.ilim = regs.wdata[CTRL_ILIM_LSB +: ILIM_W];
            end
        end
        // Only the documented key services the watchdog
        wd_kick  = regs.wr && regs.addr == REG_WDOG && regs.be[0]
                   && regs.wdata[1:0] == WDCLR_KEY;
        irq_read = regs.rd && regs.addr == REG_IRQ;

        // Watchdog saturates so a late kick still restarts it
        if (!q.wd_en || wd_kick) begin
            d.wd_ms = '0;
        end else if (tick && q.wd_ms != T_WD_MS) begin
            d.wd_ms = q.wd_ms + TMR_ONE;
        end
        wd_expired = q.wd_en && q.wd_ms == T_WD_MS;

        // Input regulation floor turns the input off until unplug
        if (!i_charger_supply_input) begin
            d.input_off = 1'b0;
        end else if (i_ilim_at_floor && i_input_below_reg) begin
            d.input_off = 1'b1;
        end

        start_ok = i_charger_supply_input && !i_battery_present_sense_n
                   && q.mode_on && !q.input_off;
        charging = q.state inside {ST_DEAD, ST_LOWPQ, ST_CC, ST_CV,
                                   ST_TOPOFF, ST_DONE};

        nxt = q.state;
        unique case (q.state)
            ST_OFF: begin
                if (start_ok) begin
                    if (!i_batt_above_dead)     nxt = ST_DEAD;
                    else if (!i_batt_above_low) nxt = ST_LOWPQ;
                    else if (!i_batt_above_reg) nxt = ST_CC;
                    else                        nxt = ST_CV;
                end
            end
            ST_DEAD: begin
                if (i_batt_above_dead) begin
                    nxt = ST_LOWPQ;
                end else if (q.state_ms >= T_PQ_MS) begin
                    nxt = ST_TFAULT;
                end
            end
            ST_LOWPQ: begin
                if (i_batt_above_low) begin
                    nxt = ST_CC;
                end else if (q.state_ms >= T_PQ_MS) begin
                    nxt = ST_TFAULT;
                end
            end
            ST_CC: begin
                if (i_batt_above_reg) begin
                    nxt = ST_CV;
                end else if (q.state_ms >= T_FC_MS) begin
                    nxt = ST_TFAULT;
                end
            end
            ST_CV: begin
                if (q.term_ms >= T_TERM_MS) begin
                    nxt = ST_TOPOFF;
                end else if (q.state_ms >= T_FC_MS) begin
                    nxt = ST_TFAULT;
                end
            end
            ST_TOPOFF: begin
                if (i_batt_below_restart) begin
                    nxt = ST_CC;
                end else if (q.state_ms >= T_TO_MS) begin
                    nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                if (i_batt_below_restart) nxt = ST_CC;
            end
            ST_TFAULT: nxt = ST_TFAULT; // Left via mode, unplug or watchdog expiry
            ST_WDSUS: begin
                if (wd_kick) nxt = ST_OFF;
            end
            default: nxt = ST_OFF;
        endcase
        if (wd_expired && (charging || q.state == ST_TFAULT)) begin
            nxt = ST_WDSUS;
        end
        // Mode off or unplug ends every state, fault included
        if (!start_ok) begin
            nxt = ST_OFF;
        end
        d.state  = nxt;
        entering = (nxt != q.state);

        // Counters restart on entry so each state times itself
        if (entering) begin
            d.state_ms = '0;
            d.blink_ms = '0;
            d.term_ms  = '0;
            d.reported = 1'b0;
        end else begin
            if (tick && q.state_ms != {TMR_W{1'b1}}) begin
                d.state_ms = q.state_ms + TMR_ONE;
            end
            if (tick) begin
                d.blink_ms = (q.blink_ms == BLINK_LAST_MS) ? '0
                             : q.blink_ms + BLK_ONE;
            end
            if (!i_chg_cur_below_topoff) begin
                d.term_ms = '0;
            end else if (tick && q.term_ms != T_TERM_MS) begin
                d.term_ms = q.term_ms + TMR_ONE;
            end
        end

        // Status codes and ok flags land one cycle before the interrupt bit
        d.chg_pend = 1'b0;
        if (entering && nxt == ST_TFAULT) begin
            d.charger_ok_flag   = 1'b0;
            d.chg_dtl  = DTL_TFAULT;
            d.chg_pend = 1'b1;
        end else if (entering && nxt == ST_WDSUS) begin
            d.charger_ok_flag   = 1'b0;
            d.chg_dtl  = DTL_WDOG;
            d.chg_pend = 1'b1;
        end else if (!entering && !q.reported
                     && q.state_ms == T_DEGLITCH_MS) begin
            d.reported = 1'b1;
            unique case (q.state)
                ST_DEAD: begin
                    d.charger_ok_flag = 1'b1; d.chg_dtl = DTL_DEAD;
                    d.chg_pend = 1'b1;
                end
                ST_CC: begin
                    d.charger_ok_flag = 1'b1; d.chg_dtl = DTL_CC;
                    d.chg_pend = 1'b1;
                end
                ST_TOPOFF: begin
                    d.charger_ok_flag = 1'b1; d.chg_dtl = DTL_TOPOFF;
                    d.chg_pend = 1'b1;
                end
                ST_DONE: begin
                    d.charger_ok_flag = 1'b0; d.chg_dtl = DTL_DONE;
                    d.chg_pend = 1'b1;
                end
                default: d.chg_pend = 1'b0;
            endcase
        end

        // Input regulation report, once per episode
        d.byp_pend  = 1'b0;
        d.vreg_seen = i_vreg_loop_active;
        if (!i_charger_supply_input) begin
            d.bypass_ok_flag  = 1'b0;
            d.byp_dtl = BYP_DTL_OK;
        end else if (i_vreg_loop_active && !q.vreg_seen) begin
            d.bypass_ok_flag   = 1'b0;
            d.byp_dtl  = BYP_DTL_VREG;
            d.byp_pend = 1'b1;
        end else if (q.byp_dtl != BYP_DTL_VREG) begin
            d.bypass_ok_flag = 1'b1;
        end

        // Read clears, but a new event in the same cycle wins
        if (irq_read) begin
            d.chg_irq = 1'b0;
            d.byp_irq = 1'b0;
        end
        if (q.chg_pend) d.chg_irq = 1'b1;
        if (q.byp_pend) d.byp_irq = 1'b1;

        // Power stage
        d.input_on  = i_charger_supply_input && !d.input_off;
        d.buck_en   = d.input_on && q.mode_on;
        // Blocking switch closes whenever the input is off
        d.ovp_drive = !d.input_on ^ i_otp_ovp_polarity;
        d.chg_en    = nxt inside {ST_DEAD, ST_LOWPQ, ST_CC, ST_CV,
                                  ST_TOPOFF};
        // System load is served first by the analog loop; this only
        // flags the foldback causes to it
        fast         = nxt inside {ST_CC, ST_CV, ST_TOPOFF};
        d.cur_reduce = fast && (i_in_current_limited
                       || i_input_below_reg
                       || i_die_above_die_regulation_temperature);

        // Indicators follow the next state and restarted blink count
        d.pq_led  = q.ind_en && (nxt inside {ST_DEAD, ST_LOWPQ})
                    && d.blink_ms < PQ_ON_MS;
        d.chg_led = q.ind_en && ((nxt inside {ST_CC, ST_CV})
                    || (nxt == ST_TOPOFF
                        && d.blink_ms < TO_ON_MS));
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= CORE_RST;
        end else begin
            q <= d;
        end
    end

    assign o_prequal_indicator_output    = q.pq_led;
    assign o_charge_indicator_output     = q.chg_led;
    assign o_ovp_switch_drive            = q.ovp_drive;
    assign o_charger_input_on            = q.input_on;
    assign o_buck_enable                 = q.buck_en;
    assign o_charge_enable               = q.chg_en;
    assign o_charge_current_reduce       = q.cur_reduce;
    assign o_input_current_limit_setting = q.ilim;
endmodule : css_charger_seq

// ===== css_batt_model.sv
`timescale 1ns/1ps
module css_batt_model (
    // Battery voltage step, 0 = dead .. 3 = above regulation
    input  wire logic [1:0] i_level,
    // Comparator levels seen by the charger
    output logic            o_above_dead,
    output logic            o_above_low,
    output logic            o_above_reg
);
    // Thresholds are ordered, so a higher step lifts every lower one
    assign o_above_dead = i_level >= 2'h1;
    assign o_above_low  = i_level >= 2'h2;
    assign o_above_reg  = i_level == 2'h3;
endmodule : css_batt_model

// ===== css_charger_seq_asserts.sv
`timescale 1ns/1ps
module css_charger_seq_asserts
    import css_pkg::*;
(
    input wire logic i_clock, i_arst_n, i_charger_supply_input,
    input wire logic i_battery_present_sense_n, i_die_above_die_regulation_temperature,
    input wire logic i_in_current_limited, i_input_below_reg,
    input wire logic i_ilim_at_floor, i_otp_ovp_polarity,
    input wire logic o_prequal_indicator_output, o_charge_indicator_output,
    input wire logic o_ovp_switch_drive, o_charger_input_on, o_buck_enable,
    input wire logic o_charge_enable, o_charge_current_reduce,
    input wire logic [6:0] o_input_current_limit_setting
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    a_ind_excl: assert property (
        !(o_prequal_indicator_output && o_charge_indicator_output))
        else $error("both indicators on");
    a_ind_dark: assert property (
        (o_prequal_indicator_output || o_charge_indicator_output)
        |-> o_charge_enable) else $error("indicator lit while idle");
    a_reduce_cause: assert property (
        o_charge_current_reduce |-> o_charge_enable && $past(i_die_above_die_regulation_temperature
        || i_in_current_limited || i_input_below_reg))
        else $error("current cut without cause");
    a_input_valid: assert property (
        o_charger_input_on |-> $past(i_charger_supply_input))
        else $error("input on without supply");
    a_floor_cut: assert property (
        $past(i_ilim_at_floor && i_input_below_reg) |-> !o_charger_input_on)
        else $error("input not cut at floor");
    a_batt_absent: assert property (
        o_charge_enable |-> !$past(i_battery_present_sense_n))
        else $error("charging without battery");
    a_ilim_reset: assert property (
        !$past(i_arst_n) |-> o_input_current_limit_setting == ILIM_RESET)
        else $error("limit not default after reset");
    a_ovp_pol: assert property (
        $past(i_arst_n) && $stable(o_charger_input_on)
        && $stable(i_otp_ovp_polarity) |-> o_ovp_switch_drive
        == (!o_charger_input_on ^ i_otp_ovp_polarity))
        else $error("blocking switch polarity wrong");
    a_buck_input: assert property (
        o_buck_enable |-> o_charger_input_on)
        else $error("buck on without input");
endmodule : css_charger_seq_asserts
bind css_charger_seq css_charger_seq_asserts css_charger_seq_asserts_inst (.*);

// ===== css_charger_seq_tb_top.sv
`timescale 1ns/1ps
module css_charger_seq_tb_top;
    import css_pkg::*;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, sup = 0, sns_n = 0;
    logic flr = 0, strs = 0, vrg = 0, pol = 1, ci, pi, wt, ad, al, ar;
    logic [1:0] lvl = 0;
    logic [7:0] adr = 0;
    logic [31:0] wd = 0, rdat, q;
    int n_errors = 0, total_checks = 0, cyc = 0;
    logic [31:0] r_exp[4] = '{32'h20003, 32'h40002, 32'h80013, 32'h100002};
    logic [31:0] r_msk[4] = '{32'h1ff00f3, 32'h1ff0002, 32'h1ff00f3,
                              32'h1ff0002};
    always #12.5 clk = ~clk;
    css_batt_model css_batt_model_inst (.i_level(lvl), .o_above_dead(ad),
        .o_above_low(al), .o_above_reg(ar));
    css_charger_seq #(.TICK_CYCLES(4)) css_charger_seq_inst (
        .i_clock(clk), .i_arst_n(rst_n), .i_address(adr), .i_read(rd),
        .i_write(wr), .i_writedata(wd), .i_byteenable(4'hf),
        .o_readdata(rdat), .o_waitrequest(wt), .i_charger_supply_input(sup),
        .i_battery_present_sense_n(sns_n), .i_batt_above_dead(ad),
        .i_batt_above_low(al), .i_batt_above_reg(ar),
        .i_batt_below_restart(1'b0), .i_chg_cur_below_topoff(1'b0),
        .i_die_above_die_regulation_temperature(strs), .i_in_current_limited(strs),
        .i_input_below_reg(strs), .i_ilim_at_floor(flr),
        .i_vreg_loop_active(vrg), .i_otp_ovp_polarity(pol),
        .o_prequal_indicator_output(pi), .o_charge_indicator_output(ci),
        .o_ovp_switch_drive(), .o_charger_input_on(), .o_buck_enable(),
        .o_charge_enable(), .o_charge_current_reduce(),
        .o_input_current_limit_setting());
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wt !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic chk(input string nm, input logic [31:0] e, s);
        total_checks++;
        if (s !== e) begin
            $display("unexpected %s exp %h got %h", nm, e, s);
            n_errors++;
        end
    endtask : chk
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    // Hang guard, well beyond the roughly one thousand cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, REG_CTRL, 0);
        chk("ctrl", 32'h0f05, q);
        bus(0, 8'h10, 0);
        chk("unmapped", 0, q);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            sup <= 1'b0;
            repeat (4) @(posedge clk);
            lvl <= 2'(i);
            sup <= 1'b1;
            repeat (3) @(posedge clk);
            chk("pq ind on", 32'(i < 2), {31'h0, pi});
            repeat (200) @(posedge clk);
            bus(0, REG_STAT, 0);
            chk("stat", r_exp[i], q & r_msk[i]);
            chk("chg ind", 32'(i > 1), {31'h0, ci});
            chk("pq ind off", 0, {31'h0, pi});
            $display("row %0d done", i);
        end
        bus(0, REG_IRQ, 0);
        chk("irq", 32'h1, q);
        bus(0, REG_IRQ, 0);
        chk("irq cleared", 0, q);
        vrg <= 1'b1;
        repeat (4) @(posedge clk);
        bus(0, REG_STAT, 0);
        chk("byp stat", 32'h800, q & 32'hf02);
        bus(0, REG_IRQ, 0);
        chk("byp irq", 32'h2, q);
        $display("bypass test done");
        bus(1, REG_CTRL, 32'h0f06);
        bus(1, REG_WDOG, 32'h1);
        repeat (4) @(posedge clk);
        chk("ind off", 0, {31'h0, ci});
        // Shutdown mid-run must drop every control bit to default
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, REG_CTRL, 0);
        chk("ctrl after reset", 32'h0f05, q);
        $display("mid-run reset test done");
        strs <= 1'b1;
        repeat (4) @(posedge clk);
        flr <= 1'b1;
        repeat (8) @(posedge clk);
        bus(0, REG_STAT, 0);
        chk("floor", 32'h10000, q & 32'h1ff0000);
        $display("floor test done");
        {sup, flr, strs, sns_n, pol} <= 5'h2;
        repeat (4) @(posedge clk);
        sup <= 1'b1;
        repeat (20) @(posedge clk);
        bus(0, REG_STAT, 0);
        chk("no batt", 32'h10000, q & 32'h1ff0000);
        $display("battery test done");
        end_of_test();
    end
endmodule : css_charger_seq_tb_top
